// *** logic/cjc_defines.svh ***
/*
 * Constants of the joystick identifier and port configuration block.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef CJC_DEFINES_SVH
`define CJC_DEFINES_SVH

// identifier layout
`define CJC_ID_W 11
`define CJC_PRIO_W 3
`define CJC_SA_W 8
`define CJC_PRIO_LOW 3'h2
`define CJC_PRIO_HIGH 3'h3
`define CJC_PRIO_DEF 3'h2
`define CJC_SA_RIGHT 8'hFE
`define CJC_SA_LEFT 8'hFF

// parameter group numbers
`define CJC_PGN_W 16
`define CJC_BASIC_T1 16'hFDD6
`define CJC_BASIC_T2 16'hFDD8
`define CJC_BASIC_T3 16'hFDDA
`define CJC_EXT_T1 16'hFDD7
`define CJC_EXT_T2 16'hFDD9
`define CJC_EXT_T3 16'hFDDB

// watchdog timeout
`define CJC_TMO_W 6
`define CJC_TMO_MAX_S 6'h3C
`define CJC_TMO_DEF_S 6'h3C
`define CJC_CLK_HZ 100000000

// port counts
`define CJC_NUM_DIO 2
`define CJC_NUM_IN 7

`endif

// *** logic/cjc_pkg.sv ***
/*
 * Types shared by the joystick configuration block.
 * Assumes cjc_defines.svh is on the include path.
 */
`include "cjc_defines.svh"

package cjc_pkg;

   // function of a configurable port
   typedef enum logic [3:0] {
      no_function,
      presence_input,
      axis1_plus_output,
      axis1_minus_output,
      axis1_off_centre_output,
      axis2_plus_output,
      axis2_minus_output,
      axis2_off_centre_output,
      indicator_output
   } cjc_func_t;

   // standard group type selection
   typedef enum logic [1:0] {
      group_type_1,
      group_type_2,
      group_type_3,
      group_custom
   } cjc_gtype_t;

   typedef enum logic {
      fault_lamp_mode,
      healthy_lamp_mode
   } cjc_lamp_t;

   typedef enum logic {
      presence_permanent_mode,
      presence_toggle_mode
   } cjc_pmode_t;

endpackage

// *** logic/cjc_presence.sv ***
/*
 * Dead-man presence watch: permanent level or toggle watchdog.
 * Assumes the input is already synchronised to clock; active high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cjc_defines.svh"

module cjc_presence #(
   parameter int unsigned CLK_HZ = `CJC_CLK_HZ // cycles per second
) (
   input wire logic clock, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic clk_en, // freezes state while low
   input wire logic pres_in, // synced presence level, 1 = grounded
   input wire cjc_pkg::cjc_pmode_t mode, // permanent or toggle
   input wire logic [`CJC_TMO_W-1:0] tmo_s, // toggle timeout, seconds
   output logic present // outputs may be enabled
);
   import cjc_pkg::*;

   // elaboration refuses a clock too slow for the seconds divider
   if (CLK_HZ < 2) begin : g_bad_clk
      $error("cjc_presence: CLK_HZ too small");
   end

   typedef struct packed {
      logic prev;
      logic [31:0] sub;
      logic [`CJC_TMO_W-1:0] secs;
      logic ok;
   } cjc_pres_st_t;

   cjc_pres_st_t st_r, st_nxt;

   assign present = st_r.ok;

   // count whole seconds since the last edge; any edge restarts
   always_comb begin
      st_nxt = st_r;
      st_nxt.prev = pres_in;
      if (mode == presence_permanent_mode) begin
         st_nxt.ok = pres_in;
         st_nxt.sub = 32'h0;
         st_nxt.secs = '0;
      end else if (pres_in != st_r.prev) begin
         st_nxt.sub = 32'h0;
         st_nxt.secs = '0;
         st_nxt.ok = (tmo_s != '0); // zero timeout never enables
      end else begin
         if (st_r.sub == CLK_HZ - 1) begin
            st_nxt.sub = 32'h0;
            if (st_r.secs != '1)
               st_nxt.secs = st_r.secs + 1'b1;
         end else begin
            st_nxt.sub = st_r.sub + 32'h1;
         end
         // no edge for longer than the timeout counts as released
         if (st_r.secs >= tmo_s)
            st_nxt.ok = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

endmodule

`default_nettype wire

// *** logic/cjc_core.sv ***
/*
 * Joystick node configuration: identifier, group numbers, port
 * functions, status lamp and dead-man gating of axis signals.
 * Assumes configuration ports are static or same-clock logic; port
 * pins and the presence input arrive asynchronously.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cjc_defines.svh"

module cjc_core #(
   parameter int unsigned CLK_HZ = `CJC_CLK_HZ, // clock rate
   parameter int unsigned AXIS_W = 8, // signed axis position width
   parameter bit LEFT_UNIT = 1'b0 // picks the default source address
) (
   input wire logic clock, // 100 MHz system clock
   input wire logic rst_n, // async reset, active low
   input wire logic clk_en, // freezes all state while low
   input wire logic [`CJC_PRIO_W-1:0] id_priority_field, // priority
   input wire logic [`CJC_SA_W-1:0] source_address, // address byte
   input wire logic use_default_address, // 1 = side default address
   input wire cjc_pkg::cjc_gtype_t standard_group_type_select, // type
   input wire logic [`CJC_PGN_W-1:0] custom_basic_group_number, // basic
   input wire logic [`CJC_PGN_W-1:0] custom_extended_group_number, // ext
   input wire cjc_pkg::cjc_func_t port1_function_select, // port 1 use
   input wire cjc_pkg::cjc_func_t port2_function_select, // port 2 use
   input wire logic [`CJC_NUM_IN-1:0] presence_select, // dead-man input
   input wire logic [`CJC_NUM_IN-1:0] floating_select, // floating input
   input wire cjc_pkg::cjc_lamp_t lamp_mode, // fault or ready lamp
   input wire cjc_pkg::cjc_pmode_t presence_mode, // permanent/toggle
   input wire logic [`CJC_TMO_W-1:0] presence_toggle_timeout, // seconds
   input wire logic [AXIS_W-1:0] axis1_pos, // signed, 0 = centre
   input wire logic [AXIS_W-1:0] axis2_pos, // signed, 0 = centre
   input wire logic [AXIS_W-1:0] axis1_band, // dead band half width
   input wire logic [AXIS_W-1:0] axis2_band, // dead band half width
   input wire logic fault, // fault present
   input wire logic [`CJC_NUM_IN-1:0] port_pin_in, // 1 = grounded
   output logic [`CJC_ID_W-1:0] message_id, // 11-bit identifier
   output logic [`CJC_PGN_W-1:0] basic_group_number, // basic PGN
   output logic [`CJC_PGN_W-1:0] extended_group_number, // extended PGN
   output logic [`CJC_NUM_IN-1:0] port_levels, // reported levels
   output logic [`CJC_NUM_DIO-1:0] port_out, // port drive, 1 = on
   output logic [`CJC_NUM_DIO-1:0] port_oe, // port drive enable
   output logic [AXIS_W-1:0] axis1_out, // gated axis 1
   output logic [AXIS_W-1:0] axis2_out, // gated axis 2
   output logic [3:0] axis_dir, // a1+, a1-, a2+, a2-
   output logic outputs_enabled, // dead-man presence
   output logic config_error // bad priority or dup input
);
   import cjc_pkg::*;

   // elaboration refuses widths the sign logic and ports cannot serve
   if (AXIS_W < 2 || AXIS_W > 16) begin : g_bad_axis
      $error("cjc_core: bad AXIS_W");
   end
   // below two cycles per second the seconds divider cannot count
   if (CLK_HZ < 2) begin : g_bad_clk
      $error("cjc_core: bad CLK_HZ");
   end

   ////////////////////////////////////////////////////////////////////
   // helpers

   // true when more than one bit is set; more than one is an illegal assignment
   // v & (v - 1) clears the lowest set bit; anything left means at least two
   function automatic logic many_set(input logic [`CJC_NUM_IN-1:0] v);
      return (v & (v - 1'b1)) != '0;
   endfunction

   // standard group number table
   // an unused code falls back to type 1, the power-up selection
   function automatic logic [`CJC_PGN_W-1:0] std_pgn(
      input cjc_gtype_t t, input logic ext);
      logic [`CJC_PGN_W-1:0] p;
      p = ext ? `CJC_EXT_T1 : `CJC_BASIC_T1;
      case (t)
         group_type_2: p = ext ? `CJC_EXT_T2 : `CJC_BASIC_T2;
         group_type_3: p = ext ? `CJC_EXT_T3 : `CJC_BASIC_T3;
         default: p = ext ? `CJC_EXT_T1 : `CJC_BASIC_T1;
      endcase
      return p;
   endfunction

   // signed position outside the band, plus (dir=1) or minus side
   // the band edge itself stays neutral; one bit of headroom keeps
   // the negated band from wrapping
   function automatic logic beyond(input logic [AXIS_W-1:0] pos,
      input logic [AXIS_W-1:0] band, input logic dir);
      logic signed [AXIS_W:0] sp;
      logic signed [AXIS_W:0] sb;
      sp = {pos[AXIS_W-1], pos};
      sb = {1'b0, band};
      return dir ? (sp > sb) : (sp < -sb);
   endfunction

   // drive of one configurable port for its function
   // an input function leaves the pin to its pull-up
   function automatic logic port_drive(input cjc_func_t f,
      input logic [3:0] d, input logic lamp);
      logic o;
      o = 1'b0;
      case (f)
         axis1_plus_output: o = d[3];
         axis1_minus_output: o = d[2];
         axis1_off_centre_output: o = d[3] | d[2];
         axis2_plus_output: o = d[1];
         axis2_minus_output: o = d[0];
         axis2_off_centre_output: o = d[1] | d[0];
         indicator_output: o = lamp;
         default: o = 1'b0;
      endcase
      return o;
   endfunction

   // only output functions turn the driver on
   function automatic logic is_output(input cjc_func_t f);
      return !(f == no_function || f == presence_input);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // state

   // all state but the presence watch in one struct so reset and clock enable cover it whole
   typedef struct packed {
      logic [`CJC_NUM_IN-1:0] sync1;
      logic [`CJC_NUM_IN-1:0] sync2;
      logic [`CJC_ID_W-1:0] id;
      logic [`CJC_PGN_W-1:0] bpgn;
      logic [`CJC_PGN_W-1:0] epgn;
      logic [`CJC_NUM_IN-1:0] levels;
      logic [`CJC_NUM_DIO-1:0] pout;
      logic [`CJC_NUM_DIO-1:0] poe;
      logic [AXIS_W-1:0] a1;
      logic [AXIS_W-1:0] a2;
      logic [3:0] dir;
      logic cfg_err;
   } cjc_core_st_t;

   cjc_core_st_t st_r, st_nxt;
   logic pres_level;
   logic present;
   logic [3:0] dir_raw;
   logic lamp;
   logic bad_prio;
   logic [`CJC_SA_W-1:0] sa;
   logic [`CJC_TMO_W-1:0] tmo_eff;
   cjc_pmode_t pres_mode;

   ////////////////////////////////////////////////////////////////////
   // dead-man presence

   // one selected input feeds the watch; none selected means enabled
   // only the second synchroniser stage is read here
   always_comb begin
      if (presence_select == '0)
         pres_level = 1'b1;
      else
         pres_level = |(presence_select & st_r.sync2);
   end

   // a timeout past the top of the range clamps to it, so a stray
   // setting cannot stretch the watchdog beyond the promised limit
   // with no dead-man input chosen the watch runs permanent on a
   // constant level; a toggle watch would time out and freeze the axes
   always_comb begin
      if (presence_toggle_timeout > `CJC_TMO_MAX_S)
         tmo_eff = `CJC_TMO_MAX_S;
      else
         tmo_eff = presence_toggle_timeout;
      if (presence_select == '0)
         pres_mode = presence_permanent_mode;
      else
         pres_mode = presence_mode;
   end

   cjc_presence #(
      .CLK_HZ(CLK_HZ)
   ) u_presence (
      .clock(clock),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .pres_in(pres_level),
      .mode(pres_mode),
      .tmo_s(tmo_eff),
      .present(present)
   );

   ////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      st_nxt = st_r;
      // pins pass two flops before any use
      // a level is reported three cycles after the pin moves
      st_nxt.sync1 = port_pin_in;
      st_nxt.sync2 = st_r.sync1;
      st_nxt.levels = st_r.sync2;

      // illegal priority falls back to the default
      // and is flagged in config_error as well
      bad_prio = !(id_priority_field == `CJC_PRIO_LOW ||
         id_priority_field == `CJC_PRIO_HIGH);
      sa = use_default_address ?
         (LEFT_UNIT ? `CJC_SA_LEFT : `CJC_SA_RIGHT) : source_address;
      // one identifier for both protocols
      st_nxt.id = {bad_prio ? `CJC_PRIO_DEF : id_priority_field,
         sa};

      // custom numbers replace the table only when selected
      // custom numbers pass unchecked; their meaning is the machine's
      if (standard_group_type_select == group_custom) begin
         st_nxt.bpgn = custom_basic_group_number;
         st_nxt.epgn = custom_extended_group_number;
      end else begin
         st_nxt.bpgn = std_pgn(standard_group_type_select,
            1'b0);
         st_nxt.epgn = std_pgn(standard_group_type_select,
            1'b1);
      end

      // duplicated input functions are flagged and not served
      // flagged rather than resolved: picking one input silently
      // would hide a wiring fault from the machine side
      st_nxt.cfg_err = bad_prio || many_set(presence_select) ||
         many_set(floating_select);

      // direction flags before gating
      dir_raw[3] = beyond(axis1_pos, axis1_band, 1'b1);
      dir_raw[2] = beyond(axis1_pos, axis1_band, 1'b0);
      dir_raw[1] = beyond(axis2_pos, axis2_band, 1'b1);
      dir_raw[0] = beyond(axis2_pos, axis2_band, 1'b0);

      // no presence: everything to neutral in one step, no ramp
      // a duplicated dead-man selection is refused the same way
      if (present && !many_set(presence_select)) begin
         st_nxt.a1 = axis1_pos;
         st_nxt.a2 = axis2_pos;
         st_nxt.dir = dir_raw;
      end else begin
         st_nxt.a1 = '0;
         st_nxt.a2 = '0;
         st_nxt.dir = '0;
      end

      // lamp sense follows the mode
      lamp = (lamp_mode == fault_lamp_mode) ? fault :
         !fault;

      // configurable port drive, from the gated directions
      // so a released dead-man input drops direction outputs too
      st_nxt.pout[0] = port_drive(port1_function_select, st_nxt.dir,
         lamp);
      st_nxt.pout[1] = port_drive(port2_function_select, st_nxt.dir,
         lamp);
      st_nxt.poe[0] = is_output(port1_function_select);
      st_nxt.poe[1] = is_output(port2_function_select);
   end

   ////////////////////////////////////////////////////////////////////
   // registers

   // clock enable low holds every field, synchronisers included
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   // plain register fields, no logic after the flops
   assign message_id = st_r.id;
   assign basic_group_number = st_r.bpgn;
   assign extended_group_number = st_r.epgn;
   assign port_levels = st_r.levels;
   assign port_out = st_r.pout;
   assign port_oe = st_r.poe;
   assign axis1_out = st_r.a1;
   assign axis2_out = st_r.a2;
   assign axis_dir = st_r.dir;
   assign outputs_enabled = present;
   assign config_error = st_r.cfg_err;

endmodule

`default_nettype wire

// *** verification/cjc_core_assertions.sv ***
/* Checker for cjc_core, bound to every instance below.
   Assumes cjc_pkg and cjc_defines.svh are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "cjc_defines.svh"
module cjc_core_assertions #(
   parameter bit LEFT_UNIT = 1'b0 // default address side
) (
   input wire logic clock, // system clock
   input wire logic rst_n, // async reset, low
   input wire logic clk_en, // run enable
   input wire logic [`CJC_PRIO_W-1:0] id_priority_field, // priority
   input wire logic [`CJC_SA_W-1:0] source_address, // address
   input wire logic use_default_address, // side default
   input wire cjc_pkg::cjc_gtype_t standard_group_type_select, // type
   input wire logic [`CJC_PGN_W-1:0] custom_basic_group_number, // basic
   input wire logic [`CJC_PGN_W-1:0] custom_extended_group_number, // ext
   input wire cjc_pkg::cjc_func_t port1_function_select, // port 1
   input wire logic [`CJC_NUM_IN-1:0] presence_select, // dead-man
   input wire logic [`CJC_NUM_IN-1:0] floating_select, // floating
   input wire logic [7:0] axis1_pos, // axis 1
   input wire logic [7:0] axis1_band, // band 1
   input wire logic [`CJC_ID_W-1:0] message_id, // identifier
   input wire logic [`CJC_PGN_W-1:0] basic_group_number, // basic
   input wire logic [`CJC_PGN_W-1:0] extended_group_number, // ext
   input wire logic [`CJC_NUM_DIO-1:0] port_oe, // drive enable
   input wire logic [7:0] axis1_out, // gated axis 1
   input wire logic [7:0] axis2_out, // gated axis 2
   input wire logic [3:0] axis_dir, // directions
   input wire logic outputs_enabled, // presence
   input wire logic config_error // config fault
);
   import cjc_pkg::*;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic ok_r; // last edge ran out of reset with clock enabled
   logic signed [8:0] pos9;
   logic signed [8:0] band9;
   logic [1:0] dir_w;

   ////////////////////////////////////////////////////////////////////
   // qualifies one-cycle answers; stale values right after reset
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ok_r <= 1'b0;
      end else begin
         ok_r <= clk_en;
      end
   end
   // strictly outside the band, the band edge itself stays neutral
   assign pos9 = {axis1_pos[7], axis1_pos};
   assign band9 = {1'b0, axis1_band};
   assign dir_w = {pos9 > band9, pos9 < -band9};

   // standard numbers sit two apart, extended one above basic
   function automatic logic [15:0] pgn(cjc_gtype_t t, logic [15:0] c,
                                       logic e);
      return (t == group_custom) ? c : 16'hFDD6 + {13'h0, t, e};
   endfunction

   property p_prio;
      ok_r |-> message_id[10:8] == ($past(id_priority_field) == 3'h3 ?
                                    3'h3 : 3'h2);
   endproperty
   a_prio: assert property (p_prio)
      else $error("priority bits wrong");
   property p_addr;
      ok_r |-> message_id[7:0] == ($past(use_default_address) ?
               (8'hFE | 8'(LEFT_UNIT)) : $past(source_address));
   endproperty
   a_addr: assert property (p_addr)
      else $error("address bits wrong");
   property p_pgn;
      ok_r |-> basic_group_number == pgn($past(standard_group_type_select),
         $past(custom_basic_group_number), 1'b0) && extended_group_number ==
         pgn($past(standard_group_type_select),
         $past(custom_extended_group_number), 1'b1);
   endproperty
   a_pgn: assert property (p_pgn)
      else $error("group number wrong");
   property p_err;
      ok_r |-> config_error == ($past(id_priority_field[2:1]) != 2'h1 ||
         $countones($past(presence_select)) > 1 ||
         $countones($past(floating_select)) > 1);
   endproperty
   a_err: assert property (p_err)
      else $error("config error wrong");
   property p_oe;
      ok_r |-> port_oe[0] ==
         ($past(port1_function_select) >= axis1_plus_output);
   endproperty
   a_oe: assert property (p_oe)
      else $error("port drive enable wrong");
   property p_neutral;
      !outputs_enabled && clk_en |=> axis1_out == 8'h00 && axis2_out == 8'h00
         && axis_dir == 4'h0;
   endproperty
   a_neutral: assert property (p_neutral)
      else $error("axes not neutral");
   property p_follow;
      outputs_enabled && clk_en && $countones(presence_select) < 2 |=>
         axis1_out == $past(axis1_pos);
   endproperty
   a_follow: assert property (p_follow)
      else $error("axis 1 not passed");
   property p_dir;
      outputs_enabled && clk_en && $countones(presence_select) < 2 |=>
         axis_dir[3:2] == $past(dir_w);
   endproperty
   a_dir: assert property (p_dir)
      else $error("axis 1 direction wrong");
   c_custom: cover property (standard_group_type_select == group_custom
      ##1 ok_r);
   c_err: cover property ($rose(config_error));
   c_drop: cover property ($fell(outputs_enabled));
endmodule
bind cjc_core cjc_core_assertions #(.LEFT_UNIT(LEFT_UNIT)) u_chk (.*);
`default_nettype wire

// *** verification/cjc_operator.sv ***
/* Operator-side dead-man circuit driving one input pin.
   Assumes act changes just after a clock edge; open pin reads 0. */
`timescale 1ns/1ps
`default_nettype none
module cjc_operator (
   input wire logic clock, // bench clock
   input wire logic [1:0] act, // 0 open, 1 held, 2 fast, 3 slow toggle
   output logic pin // 1 = grounded
);
   logic [2:0] cnt_r = 3'h0;
   logic tog_r = 1'b0;

   ////////////////////////////////////////////////////////////////////
   // fast toggles every 4 cycles, slow every 8, both inside timeout
   always @(posedge clock) begin
      cnt_r <= cnt_r + 3'h1;
      if (cnt_r[1:0] == 2'h3 && (act == 2'h2 || cnt_r[2])) begin
         tog_r <= !tog_r;
      end
   end
   // pull-up makes an open input read inactive
   assign pin = act[1] ? tog_r : act[0];
endmodule
`default_nettype wire

// *** verification/cjc_core_test.sv ***
/* Bench for cjc_core: drives config, pins and axes, checks answers.
   Assumes the checker binds itself and cjc_operator drives pin 2. */
`timescale 1ns/1ps
`default_nettype none
`include "cjc_defines.svh"
module cjc_core_test;
   import cjc_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic [2:0] id_priority_field = 3'h2;
   logic [7:0] source_address = 8'h00;
   logic use_default_address = 1'b1;
   cjc_gtype_t standard_group_type_select = group_type_1;
   logic [15:0] custom_basic_group_number = 16'h1234;
   logic [15:0] custom_extended_group_number = 16'hABCD;
   cjc_func_t port1_function_select = no_function;
   cjc_func_t port2_function_select = no_function;
   logic [6:0] presence_select = 7'h00;
   logic [6:0] floating_select = 7'h00;
   cjc_lamp_t lamp_mode = fault_lamp_mode;
   cjc_pmode_t presence_mode = presence_permanent_mode;
   logic [5:0] presence_toggle_timeout = 6'h3C;
   logic [7:0] axis1_pos = 8'h00;
   logic [7:0] axis2_pos = 8'h05;
   logic [7:0] axis1_band = 8'h0A;
   logic [7:0] axis2_band = 8'h0A;
   logic fault = 1'b0;
   logic [6:0] pins = 7'h00;
   logic [1:0] act = 2'h0;
   logic op_pin;
   logic [6:0] port_pin_in;
   logic [10:0] message_id;
   logic [15:0] basic_group_number, extended_group_number;
   logic [6:0] port_levels;
   logic [1:0] port_out, port_oe;
   logic [7:0] axis1_out, axis2_out;
   logic [3:0] axis_dir;
   logic outputs_enabled, config_error;
   logic [7:0] pos_tab [3] = '{8'h14, 8'h0A, 8'hF5};
   logic [3:0] dir_tab [3] = '{4'h8, 4'h0, 4'h4};
   int err_total = 0;
   int checked = 0;

   ////////////////////////////////////////////////////////////////////
   // a "second" is 10 cycles so timeouts stay short
   assign port_pin_in = {pins[6:3], op_pin, pins[1:0]};
   cjc_core #(.CLK_HZ(10)) u_cjc_core (.*);
   cjc_operator u_cjc_operator (.clock(clock), .act(act), .pin(op_pin));
   always #5 clock = ~clock;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic print_verdict;
      if (err_total == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // main sequence, inputs change at the rising edge
   initial begin
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      wt(2);
      chk(message_id, 32'h2FE);
      chk(port_oe, 32'h0);
      for (int t = 0; t < 4; t++) begin
         @(posedge clock);
         standard_group_type_select <= cjc_gtype_t'(t);
         wt(2);
         chk(basic_group_number,
            t < 3 ? 32'hFDD6 + 2 * t : 32'h1234);
         chk(extended_group_number,
            t < 3 ? 32'hFDD7 + 2 * t : 32'hABCD);
      end
      // clock enable low freezes the registered group number
      @(posedge clock);
      clk_en <= 1'b0;
      standard_group_type_select <= group_type_2;
      wt(3);
      chk(basic_group_number, 32'h1234);
      @(posedge clock);
      clk_en <= 1'b1;
      wt(2);
      chk(basic_group_number, 32'hFDD8);
      for (int i = 0; i < 3; i++) begin
         @(posedge clock);
         use_default_address <= 1'b0;
         id_priority_field <= 3'(i + 3);
         source_address <= {8{i[0]}};
         wt(2);
         chk(message_id,
            {i == 0 ? 3'h3 : 3'h2, {8{i[0]}}});
         chk(config_error, i != 0);
      end
      @(posedge clock);
      id_priority_field <= 3'h2;
      floating_select <= 7'h30;
      wt(2);
      chk(config_error, 32'h1);
      @(posedge clock);
      floating_select <= 7'h10;
      presence_select <= 7'h04;
      act <= 2'h1;
      pins <= 7'h7B;
      wt(5);
      chk(config_error, 32'h0);
      chk(port_levels, 32'h7F);
      for (int i = 0; i < 4; i++) begin
         @(posedge clock);
         port1_function_select <= indicator_output;
         port2_function_select <= axis1_plus_output;
         lamp_mode <= cjc_lamp_t'(i[1]);
         fault <= i[0];
         wt(3);
         chk(port_out[0], i[0] ^ i[1]);
      end
      chk(port_oe, 32'h3);
      for (int i = 0; i < 3; i++) begin
         @(posedge clock);
         axis1_pos <= pos_tab[i];
         wt(3);
         chk(axis1_out, pos_tab[i]);
         chk(axis_dir, dir_tab[i]);
         chk(port_out[1], dir_tab[i][3]);
      end
      @(posedge clock);
      act <= 2'h0;
      wt(6);
      chk(outputs_enabled, 32'h0);
      chk(axis2_out, 32'h0);
      @(posedge clock);
      presence_mode <= presence_toggle_mode;
      presence_toggle_timeout <= 6'h00;
      act <= 2'h2;
      wt(30);
      chk(outputs_enabled, 32'h0);
      @(posedge clock);
      presence_toggle_timeout <= 6'h02;
      act <= 2'h3;
      wt(30);
      chk(outputs_enabled, 32'h1);
      @(posedge clock);
      act <= 2'h2;
      wt(10);
      @(posedge clock);
      act <= 2'h1;
      wt(10);
      chk(outputs_enabled, 32'h1);
      wt(30);
      chk(outputs_enabled, 32'h0);
      chk(axis1_out, 32'h0);
      print_verdict();
   end
   // cuts a hang far past the two hundred or so cycles expected
   initial begin
      #20000;
      err_total++;
      print_verdict();
   end
endmodule
`default_nettype wire
